// ==== hw/pbh_params.svh ====
// Constants for the bus host initiator: commands, masks and timing counts
`ifndef PBH_PARAMS_SVH
`define PBH_PARAMS_SVH

// ----------------------------------------
// Bus commands carried on the command lanes
// ----------------------------------------
`define PBH_CMD_IO_RD 4'h2
`define PBH_CMD_IO_WR 4'h3
`define PBH_CMD_CFG_RD 4'ha
`define PBH_CMD_CFG_WR 4'hb
`define PBH_CMD_DAC 4'hd

// ----------------------------------------
// Field values and masks
// ----------------------------------------
`define PBH_BE_NONE 4'hf
`define PBH_DWORD_MASK 32'hffff_fffc
`define PBH_IRQ_ONE_MASK 4'h1
`define PBH_IRQ_ALL_MASK 4'hf

// ----------------------------------------
// Timing counts in bus clocks
// ----------------------------------------
// Data clocks without a claim before master abort
`define PBH_DEVSEL_WAIT 3'h5

`endif

// ==== hw/pbh_pkg.sv ====
// Types shared by the bus host initiator
package pbh_pkg;

  // Transfer sequencer states, one-hot
  typedef enum logic [6:0] {
    st_idle = 7'h01,
    st_req = 7'h02,
    st_addr = 7'h04,
    st_addr2 = 7'h08,
    st_data = 7'h10,
    st_end = 7'h20,
    st_turn = 7'h40
  } pbh_state_type;

  // Completion status of a transaction
  typedef enum logic [1:0] {
    stat_ok = 2'h0,
    stat_stop = 2'h1,
    stat_abort = 2'h2
  } pbh_status_type;

endpackage : pbh_pkg

// ==== hw/pbh_master.sv ====
// Bus host initiator: drives framed burst transactions onto the bus pins
`timescale 1ns/100ps
`include "pbh_params.svh"
// Function
// [RULE_01] The single clock where the frame starts carries the 32-bit address.
// [RULE_02] I/O addresses are byte addresses; memory and config use DWORD addresses.
// [RULE_03] One address phase, then one or more data phases, reads or writes.
// [RULE_04] Least significant byte on lanes 7..0, most significant on 31..24.
// [RULE_05] Write data valid with initiator ready; read data valid with target ready.
// [RULE_06] Command lanes carry the command, then active-low byte enables.
// [RULE_07] Byte enables hold for the whole data phase, lane 0 to byte 0.
// [RULE_08] All bus signals except reset and interrupts sampled on rising clock.
// [RULE_09] Device logic works at any clock from 33 MHz down to DC.
// [RULE_10] A claiming target drives the select line; others read it as input.
// [RULE_11] Only the master drives the frame and holds it while more data follows.
// [RULE_12] Frame release marks the final data phase under way.
// [RULE_13] A master starts an access only while its own grant is asserted.
// [RULE_14] Configuration accesses are answered only with the chip select high.
// [RULE_15] Interrupts are level, active low, open drain, asynchronous to clock.
// [RULE_16] Single function uses only interrupt A; B to D need multi-function.
// [RULE_17] Each function of a multi-function device has its own config space.
// [RULE_18] A data phase completes only when both ready lines are asserted.
// [RULE_19] Initiator ready only when able to take read data or drive write data.
// [RULE_20] A dual address cycle sends a 64-bit address in two address phases.
// [RULE_21] The driver supplies even parity over data and command one clock later.
// [RULE_22] Shared lines are driven high a clock before floating; owners wait a clock.
module pbh_master #(
  parameter int BEAT_W = 8,
  parameter bit MULTI_FUNC = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Command from the user side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [3:0] cmd_code,
  input wire logic [31:0] cmd_addr,
  input wire logic [31:0] cmd_addr_hi,
  input wire logic [BEAT_W-1:0] cmd_beats,
  input wire logic [3:0] cmd_be,
  // Write data stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_be,
  // Read data and completion
  output logic rd_valid,
  output logic [31:0] rd_data,
  output logic done,
  output pbh_pkg::pbh_status_type done_status,
  // Arbitration
  output logic req_n,
  input wire logic gnt_n,
  // Frame and initiator ready, shared sustained lines
  input wire logic frame_in_n,
  input wire logic irdy_in_n,
  output logic frame_n,
  output logic irdy_n,
  output logic sus_oe,
  // Target responses
  input wire logic trdy_n,
  input wire logic devsel_n,
  input wire logic stop_n,
  // Address, data, command and parity lanes
  input wire logic [31:0] ad_in,
  output logic [31:0] ad_out,
  output logic ad_oe,
  output logic [3:0] cbe_n,
  output logic cbe_oe,
  output logic par,
  output logic par_oe,
  output logic idsel,
  // Interrupt lines and their filtered levels
  input wire logic [3:0] int_n,
  output logic [3:0] irq_active
);

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  pbh_pkg::pbh_state_type state, next_state;
  pbh_pkg::pbh_status_type next_done_status;
  logic next_frame_n, next_irdy_n, next_sus_oe, next_ad_oe, next_cbe_oe;
  logic next_par, next_par_oe, next_idsel, next_req_n, next_rd_valid, next_done;
  logic [31:0] next_ad_out, next_rd_data;
  logic [3:0] next_cbe_n;
  logic [3:0] cmd, next_cmd, be, next_be;
  logic [31:0] addr, next_addr, addr_hi, next_addr_hi;
  logic [BEAT_W-1:0] left, next_left, rem;
  logic [2:0] devcnt, next_devcnt;
  logic seen, next_seen, have, next_have, idle_prev;
  logic xfer, write, is_io, is_cfg, dac, bus_idle;

  // Decode of the held command
  assign write = cmd[0];
  assign is_io = (cmd == `PBH_CMD_IO_RD) || (cmd == `PBH_CMD_IO_WR);
  assign is_cfg = (cmd == `PBH_CMD_CFG_RD) || (cmd == `PBH_CMD_CFG_WR);
  assign dac = (addr_hi != 32'h0);
  // Completion sampled on the rising edge
  assign xfer = (state == pbh_pkg::st_data) && !irdy_n && !trdy_n; // see [RULE_18] [RULE_08]
  assign bus_idle = frame_in_n && irdy_in_n;
  assign rem = left - BEAT_W'(xfer);
  assign cmd_ready = (state == pbh_pkg::st_idle);
  // Next beat taken when the lanes are free
  assign wr_ready = (state == pbh_pkg::st_data) && write && stop_n
    && (!have || (xfer && left != BEAT_W'(1))); // see [RULE_19]

  // Next values of the sequencer and bus drivers
  always_comb
  begin
    logic go_turn, go_end;
    go_turn = 1'b0;
    go_end = 1'b0;
    next_state = state;
    next_frame_n = frame_n;
    next_irdy_n = irdy_n;
    next_sus_oe = sus_oe;
    next_ad_oe = ad_oe;
    next_cbe_oe = cbe_oe;
    next_ad_out = ad_out;
    next_cbe_n = cbe_n;
    next_idsel = 1'b0;
    next_req_n = req_n;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_done = 1'b0;
    next_done_status = done_status;
    next_cmd = cmd;
    next_be = be;
    next_addr = addr;
    next_addr_hi = addr_hi;
    next_left = left;
    next_devcnt = devcnt;
    next_seen = seen;
    next_have = have;
    // Parity one clock behind the lanes it covers
    next_par = ^{ad_out, cbe_n}; // see [RULE_21]
    next_par_oe = ad_oe; // see [RULE_21]
    case (state)
      pbh_pkg::st_idle:
      begin
        if (cmd_valid)
        begin
          next_state = pbh_pkg::st_req;
          next_req_n = 1'b0;
          next_cmd = cmd_code;
          next_addr = cmd_addr;
          next_addr_hi = cmd_addr_hi;
          next_left = cmd_beats;
          next_be = cmd_be;
        end
      end
      pbh_pkg::st_req:
      begin
        // Own grant and an idle bus for two clocks
        if (!gnt_n && bus_idle && idle_prev) // see [RULE_13] [RULE_22]
        begin
          next_state = pbh_pkg::st_addr;
          next_req_n = 1'b1;
          next_frame_n = 1'b0; // see [RULE_11]
          next_irdy_n = 1'b1;
          next_sus_oe = 1'b1;
          next_ad_oe = 1'b1;
          next_cbe_oe = 1'b1;
          next_idsel = is_cfg && !dac; // see [RULE_14] [RULE_17]
          // Address phase lanes, low half first for a dual cycle
          next_ad_out = is_io ? addr : (addr & `PBH_DWORD_MASK); // see [RULE_01] [RULE_02]
          next_cbe_n = dac ? `PBH_CMD_DAC : cmd; // see [RULE_06] [RULE_20]
        end
      end
      pbh_pkg::st_addr, pbh_pkg::st_addr2:
      begin
        if (state == pbh_pkg::st_addr && dac)
        begin
          next_state = pbh_pkg::st_addr2;
          next_ad_out = addr_hi; // see [RULE_20]
          next_cbe_n = cmd;
          next_idsel = is_cfg;
        end
        else
        begin
          next_state = pbh_pkg::st_data; // see [RULE_03]
          next_ad_oe = write;
          next_cbe_n = ~be; // see [RULE_06] [RULE_07]
          next_have = !write;
          next_irdy_n = write;
          next_frame_n = !write && (left == BEAT_W'(1)); // see [RULE_12]
          next_devcnt = 3'h0;
          next_seen = 1'b0;
        end
      end
      pbh_pkg::st_data:
      begin
        if (write)
          next_have = (have && !xfer) || (wr_valid && wr_ready);
        else
          next_have = !(xfer && left == BEAT_W'(1));
        // New write beat onto the lanes, byte 0 on the low lanes
        if (wr_valid && wr_ready)
        begin
          next_ad_out = wr_data; // see [RULE_04] [RULE_05]
          next_cbe_n = ~wr_be; // see [RULE_07]
        end
        next_irdy_n = !next_have; // see [RULE_19]
        next_frame_n = frame_n || (rem == BEAT_W'(1) && next_have); // see [RULE_11] [RULE_12]
        next_left = rem;
        if (xfer && !write)
        begin
          next_rd_data = ad_in; // see [RULE_05] [RULE_04]
          next_rd_valid = 1'b1;
        end
        // Claim watch for master abort
        if (!devsel_n) // see [RULE_10]
          next_seen = 1'b1;
        else if (!seen)
          next_devcnt = devcnt + 3'h1; // see [RULE_09]
        if (xfer && left == BEAT_W'(1))
        begin
          go_turn = 1'b1;
          next_done = 1'b1;
          next_done_status = pbh_pkg::stat_ok;
        end
        else if (!stop_n || (!seen && devcnt == `PBH_DEVSEL_WAIT))
        begin
          go_end = !frame_n;
          go_turn = frame_n;
          next_done = 1'b1;
          next_done_status = !stop_n ? pbh_pkg::stat_stop : pbh_pkg::stat_abort;
        end
      end
      pbh_pkg::st_end:
      begin
        go_turn = 1'b1;
      end
      pbh_pkg::st_turn:
      begin
        // Lines were driven high last clock, now float
        next_state = pbh_pkg::st_idle;
        next_sus_oe = 1'b0; // see [RULE_22]
      end
      default:
      begin
        next_state = pbh_pkg::st_idle;
        next_sus_oe = 1'b0;
        next_ad_oe = 1'b0;
        next_cbe_oe = 1'b0;
        next_frame_n = 1'b1;
        next_irdy_n = 1'b1;
      end
    endcase
    // Final phase with no lanes enabled
    if (go_end)
    begin
      next_state = pbh_pkg::st_end;
      next_frame_n = 1'b1; // see [RULE_12]
      next_irdy_n = 1'b0;
      next_cbe_n = `PBH_BE_NONE;
    end
    // Drive shared lines high for one clock
    if (go_turn)
    begin
      next_state = pbh_pkg::st_turn;
      next_frame_n = 1'b1; // see [RULE_22]
      next_irdy_n = 1'b1;
      next_ad_oe = 1'b0;
      next_cbe_oe = 1'b0;
      next_have = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= pbh_pkg::st_idle;
      frame_n <= 1'b1;
      irdy_n <= 1'b1;
      sus_oe <= 1'b0;
      ad_oe <= 1'b0;
      cbe_oe <= 1'b0;
      ad_out <= 32'h0;
      cbe_n <= `PBH_BE_NONE;
      par <= 1'b0;
      par_oe <= 1'b0;
      idsel <= 1'b0;
      req_n <= 1'b1;
      rd_valid <= 1'b0;
      rd_data <= 32'h0;
      done <= 1'b0;
      done_status <= pbh_pkg::stat_ok;
      cmd <= 4'h0;
      be <= 4'h0;
      addr <= 32'h0;
      addr_hi <= 32'h0;
      left <= '0;
      devcnt <= 3'h0;
      seen <= 1'b0;
      have <= 1'b0;
      idle_prev <= 1'b0;
    end
    else
    begin
      state <= next_state;
      frame_n <= next_frame_n;
      irdy_n <= next_irdy_n;
      sus_oe <= next_sus_oe;
      ad_oe <= next_ad_oe;
      cbe_oe <= next_cbe_oe;
      ad_out <= next_ad_out;
      cbe_n <= next_cbe_n;
      par <= next_par;
      par_oe <= next_par_oe;
      idsel <= next_idsel;
      req_n <= next_req_n;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      done <= next_done;
      done_status <= next_done_status;
      cmd <= next_cmd;
      be <= next_be;
      addr <= next_addr;
      addr_hi <= next_addr_hi;
      left <= next_left;
      devcnt <= next_devcnt;
      seen <= next_seen;
      have <= next_have;
      idle_prev <= bus_idle;
    end
  end

  // ----------------------------------------
  // Interrupt level filter
  // ----------------------------------------
  logic [3:0] int_s1, int_s2, int_s3, irq_level, next_irq_level;

  // Level follows once the last two stages agree
  always_comb
  begin
    next_irq_level = irq_level;
    for (int i = 0; i < 4; i++)
      if (int_s2[i] == int_s3[i])
        next_irq_level[i] = !int_s3[i]; // see [RULE_15]
  end

  // Three stage capture of the asynchronous lines
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_s1 <= 4'hf;
      int_s2 <= 4'hf;
      int_s3 <= 4'hf;
      irq_level <= 4'h0;
    end
    else
    begin
      int_s1 <= int_n;
      int_s2 <= int_s1;
      int_s3 <= int_s2;
      irq_level <= next_irq_level;
    end
  end

  // Only line A counts on a single-function device
  assign irq_active = irq_level
    & (MULTI_FUNC ? `PBH_IRQ_ALL_MASK : `PBH_IRQ_ONE_MASK); // see [RULE_16]

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_addr_phase: assert property (state == pbh_pkg::st_addr |-> !frame_n && ad_oe && cbe_oe
    && $past(frame_n)) else $error("address phase not framed"); // see [RULE_01]
  chk_start_grant: assert property ($rose(sus_oe) |-> $past(!gnt_n) && $past(bus_idle, 1)
    && $past(bus_idle, 2)) else $error("start without grant or idle bus"); // see [RULE_13]
  chk_frame_last: assert property ($rose(frame_n) && state == pbh_pkg::st_data |-> !irdy_n)
    else $error("frame released without ready"); // see [RULE_12]
  chk_release_high: assert property ($fell(sus_oe) |-> $past(frame_n) && $past(irdy_n))
    else $error("line floated while low"); // see [RULE_22]
  chk_parity_lag: assert property (##1 par_oe |-> par == ^{$past(ad_out), $past(cbe_n)})
    else $error("parity mismatch"); // see [RULE_21]
  chk_read_take: assert property (rd_valid |-> $past(!irdy_n) && $past(!trdy_n)
    && rd_data == $past(ad_in)) else $error("read taken without both ready"); // see [RULE_18]
  chk_write_valid: assert property (state == pbh_pkg::st_data && write && !irdy_n |-> ad_oe)
    else $error("write ready without data"); // see [RULE_19]
  chk_dword_addr: assert property (state == pbh_pkg::st_addr && !is_io |-> ad_out[1:0] == 2'h0)
    else $error("non-I/O address not aligned"); // see [RULE_02]
  chk_dac_pair: assert property (state == pbh_pkg::st_addr && cbe_n == `PBH_CMD_DAC |=>
    state == pbh_pkg::st_addr2 && ad_out == addr_hi) else $error("second address missing"); // see [RULE_20]
  chk_irq_agree: assert property ($changed(irq_level) |-> $past(int_s2) == $past(int_s3))
    else $error("interrupt level changed unfiltered"); // see [RULE_15]

endmodule : pbh_master

// ==== bench/pbh_target_model.sv ====
// Target and arbiter model facing the bus host initiator
`timescale 1ns/100ps
`include "pbh_params.svh"
module pbh_target_model (
  // Clock, reset and scenario controls
  input wire logic clock,
  input wire logic rst_n,
  input wire logic claim_en,
  input wire logic stop_en,
  input wire logic [3:0] trdy_wait,
  input wire logic [3:0] gnt_lag,
  // Lines from the initiator
  input wire logic req_n,
  input wire logic frame_in_n,
  input wire logic irdy_in_n,
  input wire logic [31:0] ad_out,
  input wire logic [3:0] cbe_n,
  input wire logic idsel,
  // Lines driven by the model
  output logic gnt_n,
  output logic trdy_n,
  output logic devsel_n,
  output logic stop_n,
  output logic tgt_oe,
  output logic [31:0] tgt_ad,
  // Recorded address phases
  output logic [31:0] seen_addr,
  output logic [31:0] seen_hi,
  output logic [3:0] seen_cmd,
  output logic seen_idsel
);
  logic [31:0] mem [16];
  logic active, dac_next, p_frame;
  logic [3:0] idx, cnt, lag;

  // Grant after a lag, claim, ready and read lanes
  assign gnt_n = !(!req_n && lag == gnt_lag);
  assign devsel_n = !active;
  assign trdy_n = !(active && !dac_next && cnt == trdy_wait);
  assign stop_n = !(active && stop_en && cnt == trdy_wait);
  assign tgt_oe = active && !seen_cmd[0] && !trdy_n;
  assign tgt_ad = mem[idx];

  // Edge-only decode, no minimum rate assumed
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 16; i++)
        mem[i] <= 32'h0;
      {active, dac_next, p_frame, idx, cnt, lag} <= 15'h1000;
      {seen_addr, seen_hi, seen_cmd, seen_idsel} <= 69'h0;
    end
    else
    begin
      lag <= (req_n || lag == gnt_lag) ? (req_n ? 4'h0 : lag) : lag + 4'h1;
      p_frame <= frame_in_n;
      dac_next <= 1'b0;
      if (p_frame && !frame_in_n)
      begin
        seen_addr <= ad_out;
        seen_cmd <= cbe_n;
        seen_idsel <= idsel;
        idx <= ad_out[5:2];
        cnt <= 4'h0;
        dac_next <= (cbe_n == `PBH_CMD_DAC);
        active <= claim_en && (cbe_n[3:1] != 3'h5 || idsel);
      end
      else if (dac_next)
      begin
        seen_hi <= ad_out;
        seen_cmd <= cbe_n;
      end
      else if (active && !irdy_in_n && !trdy_n)
      begin
        for (int b = 0; b < 4; b++)
          if (seen_cmd[0] && !cbe_n[b])
            mem[idx][8*b +: 8] <= ad_out[8*b +: 8];
        idx <= idx + 4'h1;
        cnt <= 4'h0;
        active <= !(frame_in_n || !stop_n);
      end
      else if (frame_in_n && irdy_in_n)
        active <= 1'b0;
      else if (active && cnt != trdy_wait)
        cnt <= cnt + 4'h1;
    end
  end
endmodule : pbh_target_model

// ==== bench/tb_top.sv ====
// Self-checking bench for the bus host initiator
`timescale 1ns/100ps
`include "pbh_params.svh"
module tb_top;
  // Stimulus and scenario controls
  logic clock = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, wr_valid = 1'b0, flt = 1'b0;
  logic [3:0] cmd_code = 4'h0, cmd_be = 4'hf, wr_be = 4'h0, int_n = 4'hf;
  logic [31:0] cmd_addr = 32'h0, cmd_addr_hi = 32'h0, wr_data = 32'h0;
  logic [7:0] cmd_beats = 8'h1;
  logic claim_en = 1'b1, stop_en = 1'b0;
  logic [3:0] trdy_wait = 4'h0, gnt_lag = 4'h0;
  // Design outputs and wire levels
  logic cmd_ready, wr_ready, rd_valid, done, req_n, gnt_n, frame_n, irdy_n, sus_oe, idsel;
  logic trdy_n, devsel_n, stop_n, ad_oe, cbe_oe, par, par_oe, tgt_oe, seen_idsel;
  logic frame_in_n, irdy_in_n;
  logic [31:0] rd_data, ad_out, ad_in, tgt_ad, seen_addr, seen_hi;
  logic [3:0] cbe_n, irq_active, seen_cmd;
  pbh_pkg::pbh_status_type done_status, st;
  // Scenario data and monitor history
  logic [31:0] wd [4], rdv [4];
  logic [3:0] wb [4];
  int nrd, mismatches = 0, check_count = 0;
  logic p_frame = 1'b1, p_gnt = 1'b1, p_sus = 1'b0, p_fn = 1'b1, p_in = 1'b1;
  logic [35:0] p_lanes = 36'h0;

  always #2.5 clock = ~clock;

  // Pulled-up shared lines, floating lanes toggle
  assign frame_in_n = sus_oe ? frame_n : 1'b1;
  assign irdy_in_n = sus_oe ? irdy_n : 1'b1;
  assign ad_in = tgt_oe ? tgt_ad : (ad_oe ? ad_out : {16{flt, !flt}});

  pbh_master dut (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_addr_hi(cmd_addr_hi), .cmd_beats(cmd_beats),
    .cmd_be(cmd_be), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_be(wr_be),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .done_status(done_status),
    .req_n(req_n), .gnt_n(gnt_n), .frame_in_n(frame_in_n), .irdy_in_n(irdy_in_n),
    .frame_n(frame_n), .irdy_n(irdy_n), .sus_oe(sus_oe), .trdy_n(trdy_n), .devsel_n(devsel_n),
    .stop_n(stop_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .cbe_n(cbe_n),
    .cbe_oe(cbe_oe), .par(par), .par_oe(par_oe), .idsel(idsel), .int_n(int_n),
    .irq_active(irq_active));

  pbh_target_model far (.clock(clock), .rst_n(rst_n), .claim_en(claim_en), .stop_en(stop_en),
    .trdy_wait(trdy_wait), .gnt_lag(gnt_lag), .req_n(req_n), .frame_in_n(frame_in_n),
    .irdy_in_n(irdy_in_n), .ad_out(ad_out), .cbe_n(cbe_n), .idsel(idsel), .gnt_n(gnt_n),
    .trdy_n(trdy_n), .devsel_n(devsel_n), .stop_n(stop_n), .tgt_oe(tgt_oe), .tgt_ad(tgt_ad),
    .seen_addr(seen_addr), .seen_hi(seen_hi), .seen_cmd(seen_cmd), .seen_idsel(seen_idsel));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Wire monitor: parity, grant before frame, release high
  always @(posedge clock)
  begin
    flt <= !flt;
    if (rst_n && par_oe === 1'b1)
      check({31'h0, par}, {31'h0, ^p_lanes});
    if (rst_n && p_frame && !frame_in_n)
      check({31'h0, p_gnt}, 32'h0);
    if (rst_n && p_sus && !sus_oe)
      check({30'h0, p_fn, p_in}, 32'h3);
    p_lanes = {ad_out, cbe_n};
    {p_frame, p_gnt, p_sus, p_fn, p_in} = {frame_in_n, gnt_n, sus_oe, frame_n, irdy_n};
  end

  // One transaction, beats fed and results gathered
  task automatic txn(input logic [3:0] code, input logic [31:0] addr, input logic [31:0] hi,
    input logic [7:0] beats);
    int k;
    bit acc, wt, fin;
    k = 0;
    fin = 1'b0;
    nrd = 0;
    @(negedge clock);
    {cmd_valid, cmd_code, cmd_addr, cmd_addr_hi, cmd_beats} = {1'b1, code, addr, hi, beats};
    {wr_valid, wr_data, wr_be} = {code[0], wd[0], wb[0]};
    for (int n = 0; n < 300 && !fin; n++)
    begin
      acc = cmd_valid && cmd_ready;
      wt = wr_valid && wr_ready;
      @(negedge clock);
      if (acc)
        cmd_valid = 1'b0;
      if (wt)
      begin
        k++;
        {wr_valid, wr_data, wr_be} = {k < beats, wd[k % 4], wb[k % 4]};
      end
      if (rd_valid === 1'b1)
      begin
        rdv[nrd % 4] = rd_data;
        nrd++;
      end
      if (done === 1'b1)
      begin
        st = done_status;
        fin = 1'b1;
      end
    end
    check({31'h0, fin}, 32'h1);
  endtask : txn

  task automatic t_burst();
    {wd[0], wb[0], wd[1], wb[1]} = {32'h1122_3344, 4'hf, 32'h5566_7788, 4'h5};
    txn(4'h7, 32'h10, 32'h0, 8'h2);
    check({30'h0, st}, {30'h0, pbh_pkg::stat_ok});
    check(seen_addr, 32'h10);
    check({28'h0, seen_cmd}, 32'h7);
    txn(4'h6, 32'h10, 32'h0, 8'h2);
    check(rdv[0], 32'h1122_3344);
    check(rdv[1], 32'h0066_0088);
    check(nrd, 32'h2);
  endtask : t_burst

  task automatic t_kinds();
    {wd[0], wb[0]} = {32'hcafe_f00d, 4'hf};
    txn(`PBH_CMD_IO_WR, 32'h23, 32'h0, 8'h1);
    check(seen_addr, 32'h23);
    txn(`PBH_CMD_IO_RD, 32'h21, 32'h0, 8'h1);
    check(seen_addr, 32'h21);
    check(rdv[0], 32'hcafe_f00d);
    txn(`PBH_CMD_CFG_RD, 32'h13, 32'h0, 8'h1);
    check(seen_addr, 32'h10);
    check({31'h0, seen_idsel}, 32'h1);
    check(rdv[0], 32'h1122_3344);
    txn(4'h6, 32'h20, 32'h1, 8'h1);
    check(seen_hi, 32'h1);
    check({28'h0, seen_cmd}, 32'h6);
    check(rdv[0], 32'hcafe_f00d);
  endtask : t_kinds

  task automatic t_wait();
    {trdy_wait, gnt_lag} = {4'h3, 4'h4};
    {wd[0], wb[0], wd[1], wb[1]} = {32'hdead_beef, 4'hf, 32'h0102_0304, 4'hf};
    txn(4'h7, 32'h30, 32'h0, 8'h2);
    txn(4'h6, 32'h30, 32'h0, 8'h2);
    check(rdv[0], 32'hdead_beef);
    check(rdv[1], 32'h0102_0304);
    {trdy_wait, gnt_lag} = 8'h0;
  endtask : t_wait

  task automatic t_refused();
    claim_en = 1'b0;
    txn(4'h6, 32'h10, 32'h0, 8'h1);
    check({30'h0, st}, {30'h0, pbh_pkg::stat_abort});
    check(nrd, 32'h0);
    {claim_en, stop_en} = 2'b11;
    txn(4'h6, 32'h10, 32'h0, 8'h3);
    check({30'h0, st}, {30'h0, pbh_pkg::stat_stop});
    stop_en = 1'b0;
  endtask : t_refused

  task automatic t_irq();
    @(negedge clock);
    int_n = 4'he;
    repeat (5) @(negedge clock);
    check({28'h0, irq_active}, 32'h1);
    int_n = 4'hd;
    repeat (5) @(negedge clock);
    check({28'h0, irq_active}, 32'h0);
    int_n = 4'hf;
  endtask : t_irq

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // Main sequence after 8 clocks of reset
  initial
  begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    t_burst();
    t_kinds();
    t_wait();
    t_refused();
    t_irq();
    complete_run();
  end

  // Watchdog for a hung handshake
  initial
  begin
    #100000;
    mismatches++;
    complete_run();
  end
endmodule : tb_top
